/* design/debug_regs_defines.vh */
// Bit positions, reset values and identity defaults of the debug registers
`ifndef DEBUG_REGS_DEFINES_VH
`define DEBUG_REGS_DEFINES_VH

`define REG_IDENTITY 1'b0
`define REG_STATUS 1'b1

`define ID_REV_LSB 0
`define ID_VAR_LSB 4
`define ID_ARCH_LSB 16
`define ID_CTX_LSB 20
`define ID_BRP_LSB 24
`define ID_WRP_LSB 28
`define ID_ARCH_CODE 4'h1

`define ST_HALTED 0
`define ST_RESTARTED 1
`define ST_CAUSE_LSB 2
`define ST_PABORT 6
`define ST_IABORT 7
`define ST_DEBUG_ACK_OUTPUT 10
`define ST_INTDIS 11
`define ST_USERDIS 12
`define ST_EXECEN 13
`define ST_HALTSEL 14
`define ST_MONEN 15
`define ST_OUT_FULL 29
`define ST_IN_FULL 30

`define CTRL_RESET 1'b0
`define CAUSE_RESET 4'h0
`define DATA_RESET 32'h0000_0000

`endif

/* design/transfer_word.v */
// One 32-bit transfer word of the comms channel with a full flag
`timescale 1ns/10ps
module transfer_word #(
    parameter WIDTH = 32
) (
    input wire mclk,
    input wire rst,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    output reg [WIDTH-1:0] rd_data,
    output reg full
);
    // Word storage and read data register
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= {WIDTH{1'b0}};
        end else if (wr_en) begin
            rd_data <= wr_data;
        end
    end

    // Full flag, a write wins over a read in the same cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            full <= 1'b0;
        end else if (wr_en) begin
            full <= 1'b1;
        end else if (rd_en) begin
            full <= 1'b0;
        end
    end
endmodule

/* design/sync3.v */
// Three-stage synchroniser plus an output flip-flop for a level from outside the clock domain
`timescale 1ns/10ps
module sync3 (
    input wire mclk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Shift chain, output changes once stages two and three agree
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule

/* design/debug_id_status_registers.v */
// Debug identity and status/control registers with core and debugger views
`timescale 1ns/10ps
`include "debug_regs_defines.vh"
module debug_id_status_registers #(
    parameter [3:0] REVISION = 4'h0,
    parameter [3:0] VARIANT = 4'h0,
    parameter [3:0] CTX_PAIRS_M1 = 4'h0,
    parameter [3:0] BRP_PAIRS_M1 = 4'h2,
    parameter [3:0] WRP_PAIRS_M1 = 4'h0,
    parameter HAS_EXEC = 1
) (
    input wire mclk,
    input wire rst,
    input wire core_sel,
    input wire core_rd,
    input wire core_wr,
    input wire [31:0] core_wdata,
    output reg [31:0] core_rdata,
    input wire core_dtr_rd,
    input wire core_dtr_wr,
    input wire [31:0] core_dtr_wdata,
    output wire [31:0] core_dtr_rdata,
    input wire ext_sel,
    input wire ext_rd,
    input wire ext_wr,
    input wire [31:0] ext_wdata,
    output reg [31:0] ext_rdata,
    input wire ext_dtr_rd,
    input wire ext_dtr_wr,
    input wire [31:0] ext_dtr_wdata,
    output wire [31:0] ext_dtr_rdata,
    input wire debug_state,
    input wire exit_request,
    input wire entry_valid,
    input wire [3:0] entry_cause,
    input wire precise_abort,
    input wire imprecise_abort,
    input wire dbgen,
    output wire debug_ack_output,
    output wire irq_inhibit,
    output wire user_access_disable,
    output wire exec_enable,
    output wire [1:0] debug_mode
);
    reg [3:0] cause_q;
    reg pabort_q;
    reg iabort_q;
    reg debug_ack_output_q;
    reg intdis_q;
    reg userdis_q;
    reg execen_q;
    reg haltsel_q;
    reg monen_q;
    reg restarted_q;
    reg halted_prev_q;
    wire dbgen_s;
    wire out_full;
    wire in_full;
    wire [31:0] id_word;
    wire [31:0] status_word;
    wire core_st_rd;
    wire core_st_wr;
    wire ext_st_rd;
    wire ext_st_wr;

    // Debug enable pin passes the synchroniser
    sync3 u_dbgen_sync (
        .mclk(mclk),
        .rst(rst),
        .din(dbgen),
        .dout(dbgen_s)
    );

    // Outbound word: core writes, debugger reads
    transfer_word #(.WIDTH(32)) u_outbound (
        .mclk(mclk),
        .rst(rst),
        .wr_en(core_dtr_wr),
        .wr_data(core_dtr_wdata),
        .rd_en(ext_dtr_rd),
        .rd_data(ext_dtr_rdata),
        .full(out_full)
    );

    // Inbound word: debugger writes when empty, core reads
    transfer_word #(.WIDTH(32)) u_inbound (
        .mclk(mclk),
        .rst(rst),
        .wr_en(ext_dtr_wr & ~in_full),
        .wr_data(ext_dtr_wdata),
        .rd_en(core_dtr_rd),
        .rd_data(core_dtr_rdata),
        .full(in_full)
    );

    // Register select decode for each view
    assign core_st_rd = core_rd & (core_sel == `REG_STATUS);
    assign core_st_wr = core_wr & (core_sel == `REG_STATUS);
    assign ext_st_rd = ext_rd & (ext_sel == `REG_STATUS);
    assign ext_st_wr = ext_wr & (ext_sel == `REG_STATUS);

    // Identity word; reserved bits 15:8 read zero
    assign id_word = {WRP_PAIRS_M1,
                      BRP_PAIRS_M1,
                      CTX_PAIRS_M1,
                      `ID_ARCH_CODE,
                      8'h00,
                      VARIANT,
                      REVISION};

    // Status word; mode bits masked while debug enable is low
    assign status_word = {1'b0,
                          in_full,
                          out_full,
                          13'h0000,
                          monen_q & dbgen_s,
                          haltsel_q & dbgen_s,
                          execen_q,
                          userdis_q,
                          intdis_q,
                          debug_ack_output_q,
                          2'h0,
                          iabort_q,
                          pabort_q,
                          cause_q,
                          restarted_q,
                          debug_state};

    // Entry cause, set by debug entry or by core write
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause_q <= `CAUSE_RESET;
        end else if (entry_valid) begin
            cause_q <= entry_cause;
        end else if (core_st_wr) begin
            cause_q <= core_wdata[`ST_CAUSE_LSB+3:`ST_CAUSE_LSB];
        end
    end

    // Sticky aborts; a new abort wins over the clearing read
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pabort_q <= `CTRL_RESET;
            iabort_q <= `CTRL_RESET;
        end else begin
            if (precise_abort) begin
                pabort_q <= 1'b1;
            end else if (ext_st_rd) begin
                pabort_q <= 1'b0;
            end
            if (imprecise_abort) begin
                iabort_q <= 1'b1;
            end else if (ext_st_rd) begin
                iabort_q <= 1'b0;
            end
        end
    end

    // Debugger-owned controls; core writes ignored
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            debug_ack_output_q <= `CTRL_RESET;
            intdis_q <= `CTRL_RESET;
            execen_q <= `CTRL_RESET;
            haltsel_q <= `CTRL_RESET;
        end else if (ext_st_wr) begin
            debug_ack_output_q <= ext_wdata[`ST_DEBUG_ACK_OUTPUT];
            intdis_q <= ext_wdata[`ST_INTDIS];
            execen_q <= (HAS_EXEC != 0) & ext_wdata[`ST_EXECEN];
            haltsel_q <= ext_wdata[`ST_HALTSEL];
        end
    end

    // Core-owned controls; debugger writes ignored
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            userdis_q <= `CTRL_RESET;
            monen_q <= `CTRL_RESET;
        end else if (core_st_wr) begin
            userdis_q <= core_wdata[`ST_USERDIS];
            monen_q <= core_wdata[`ST_MONEN];
        end
    end

    // Restart tracking: cleared on exit request, set once debug state falls
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            restarted_q <= 1'b1;
            halted_prev_q <= 1'b0;
        end else begin
            halted_prev_q <= debug_state;
            if (halted_prev_q & ~debug_state) begin
                restarted_q <= 1'b1;
            end else if (exit_request & debug_state) begin
                restarted_q <= 1'b0;
            end
        end
    end

    // Registered read data for both views; reserved fields read zero
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_rdata <= `DATA_RESET;
            ext_rdata <= `DATA_RESET;
        end else begin
            if (core_rd) begin
                core_rdata <= (core_sel == `REG_STATUS) ? status_word : id_word;
            end
            if (ext_rd) begin
                ext_rdata <= (ext_sel == `REG_STATUS) ? status_word : id_word;
            end
        end
    end

    // Control outputs
    assign debug_ack_output = debug_ack_output_q | debug_state;
    assign irq_inhibit = intdis_q;
    assign user_access_disable = userdis_q;
    assign exec_enable = execen_q;
    assign debug_mode = {monen_q & dbgen_s, haltsel_q & dbgen_s};
endmodule

/* sim/debug_regs_checker_assertions.sv */
// Concurrent checks on the debug register bank ports
`timescale 1ns/10ps
module debug_regs_checker (
    input wire mclk,
    input wire rst,
    input wire core_sel,
    input wire core_rd,
    input wire [31:0] core_rdata,
    input wire core_dtr_wr,
    input wire core_dtr_rd,
    input wire ext_sel,
    input wire ext_rd,
    input wire ext_wr,
    input wire [31:0] ext_wdata,
    input wire [31:0] ext_rdata,
    input wire ext_dtr_wr,
    input wire ext_dtr_rd,
    input wire debug_state,
    input wire precise_abort,
    input wire debug_ack_output
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Debugger reads of each register
    wire st_rd = ext_rd && ext_sel;
    wire id_rd = ext_rd && !ext_sel;
    AST_ARCH: assert property (id_rd |=> ext_rdata[19:8] == 12'h100)
        else $error("identity architecture field wrong");
    AST_RSVD: assert property (st_rd |=> ext_rdata[31] == 1'b0 && ext_rdata[28:16] == 13'h0)
        else $error("reserved status bits not zero");
    AST_HALT: assert property (st_rd |=> ext_rdata[0] == $past(debug_state))
        else $error("halted bit differs from debug state");
    AST_ACK_STATE: assert property (debug_state |-> debug_ack_output)
        else $error("acknowledge low in debug state");
    AST_ACK_CTRL: assert property (ext_wr && ext_sel && ext_wdata[10] |=> debug_ack_output)
        else $error("acknowledge control not forcing output");
    AST_PSET: assert property (precise_abort ##1 st_rd |=> ext_rdata[6])
        else $error("precise abort not sticky");
    AST_PCLR: assert property (st_rd && !precise_abort ##1 st_rd && !precise_abort |=> !ext_rdata[6])
        else $error("abort bit not cleared by debugger read");
    AST_OUT: assert property (core_dtr_wr && !ext_dtr_rd ##1 st_rd && !ext_dtr_rd |=> ext_rdata[29])
        else $error("outbound full not set");
    AST_IN: assert property (ext_dtr_wr && !core_dtr_rd ##1 core_rd && core_sel |=> core_rdata[30])
        else $error("inbound full not set");
    // Main scenarios reached
    cover property (st_rd ##1 st_rd);
    cover property (ext_dtr_wr ##1 ext_dtr_wr);
    cover property (core_dtr_wr ##[1:5] ext_dtr_rd);
endmodule
bind debug_id_status_registers debug_regs_checker chk_i (.*);

/* sim/ext_debugger.sv */
// External debugger model driving the debugger view of the register bank
`timescale 1ns/10ps
module ext_debugger (
    input wire mclk,
    output reg ext_sel,
    output reg ext_rd,
    output reg ext_wr,
    output reg [31:0] ext_wdata,
    output reg ext_dtr_rd,
    output reg ext_dtr_wr,
    output reg [31:0] ext_dtr_wdata
);
    // Idle bus at time zero
    initial begin
        {ext_sel, ext_rd, ext_wr, ext_dtr_rd, ext_dtr_wr} = 5'h0;
        ext_wdata = 32'h0;
        ext_dtr_wdata = 32'h0;
    end
    // One access held n cycles; k is {rd, wr, dtr_rd, dtr_wr}
    task op(input [3:0] k, input s, input [31:0] d, input integer n);
        @(posedge mclk);
        {ext_rd, ext_wr, ext_dtr_rd, ext_dtr_wr} <= k;
        ext_sel <= s;
        ext_wdata <= d & 32'h0000_fc3c;
        ext_dtr_wdata <= d;
        repeat (n) @(posedge mclk);
        {ext_rd, ext_wr, ext_dtr_rd, ext_dtr_wr} <= 4'h0;
        ext_wdata <= ~d; // Released data scrambled
        ext_dtr_wdata <= ~d;
    endtask
endmodule

/* sim/debug_id_status_registers_tb.sv */
// Self-checking bench for the debug identity and status registers
`timescale 1ns/10ps
module debug_id_status_registers_tb;
    reg mclk, rst, core_sel, core_rd, core_wr, core_dtr_rd, core_dtr_wr, debug_state;
    reg exit_request, entry_valid, precise_abort, imprecise_abort, dbgen;
    reg [31:0] core_wdata, core_dtr_wdata;
    reg [3:0] entry_cause;
    wire [31:0] core_rdata, core_dtr_rdata, ext_rdata, ext_dtr_rdata, ext_wdata, ext_dtr_wdata;
    wire ext_sel, ext_rd, ext_wr, ext_dtr_rd, ext_dtr_wr;
    wire debug_ack_output, irq_inhibit, user_access_disable, exec_enable;
    wire [1:0] debug_mode;
    integer failures, comparisons;
    debug_id_status_registers #(.REVISION(4'h3), .VARIANT(4'h5), .CTX_PAIRS_M1(4'h1),
        .BRP_PAIRS_M1(4'h2), .WRP_PAIRS_M1(4'h4), .HAS_EXEC(1)) dut (.*);
    ext_debugger dbg (.*);
    // Clock at 25 MHz
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task chk(input string n, input [31:0] e, input [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Core access; k is {rd, wr, dtr_rd, dtr_wr}
    task cop(input [3:0] k, input s, input [31:0] d);
        @(posedge mclk);
        {core_rd, core_wr, core_dtr_rd, core_dtr_wr} <= k;
        core_sel <= s;
        core_wdata <= d;
        core_dtr_wdata <= d;
        @(posedge mclk);
        {core_rd, core_wr, core_dtr_rd, core_dtr_wr} <= 4'h0;
    endtask
    // Event pulse; k is {entry, exit, precise, imprecise}
    task ev(input [3:0] k);
        @(posedge mclk);
        {entry_valid, exit_request, precise_abort, imprecise_abort} <= k;
        @(posedge mclk);
        {entry_valid, exit_request, precise_abort, imprecise_abort} <= 4'h0;
    endtask
    task sc(input [31:0] e);
        cop(4'h8, 1'b1, 32'h0);
        #1 chk("core status", e, core_rdata);
    endtask
    task se(input [31:0] e);
        dbg.op(4'h8, 1'b1, 32'h0, 1);
        #1 chk("debugger status", e, ext_rdata);
    endtask
    task outs(input [5:0] e);
        chk("outputs", {26'h0, e}, {26'h0, debug_ack_output, irq_inhibit,
            user_access_disable, exec_enable, debug_mode});
    endtask
    task t_reset;
        se(32'h0000_0002);
        cop(4'h4, 1'b0, 32'h0);
        cop(4'h8, 1'b0, 32'h0);
        #1 chk("core identity", 32'h4211_0053, core_rdata);
        dbg.op(4'h8, 1'b0, 32'h0, 1);
        #1 chk("debugger identity", 32'h4211_0053, ext_rdata);
    endtask
    task t_ctrl;
        dbg.op(4'h4, 1'b1, 32'h0000_fc3c, 1);
        se(32'h0000_6c02);
        outs(6'b110101);
        cop(4'h4, 1'b1, 32'h0000_903c);
        sc(32'h0000_fc3e);
        outs(6'b111111);
        dbg.op(4'h4, 1'b1, 32'h0, 1);
        se(32'h0000_903e);
        outs(6'b001010);
    endtask
    task t_abort;
        fork
            ev(4'h3);
            begin @(posedge mclk); dbg.op(4'h8, 1'b1, 32'h0, 1); end
        join
        #1 chk("debugger status", 32'h0000_90fe, ext_rdata);
        ev(4'h3);
        sc(32'h0000_90fe);
        sc(32'h0000_90fe);
        dbg.op(4'h8, 1'b1, 32'h0, 2);
        #1 chk("debugger status", 32'h0000_903e, ext_rdata);
        sc(32'h0000_903e);
    endtask
    task t_dtr;
        fork
            cop(4'h1, 1'b1, 32'ha5a5_0f0f);
            begin @(posedge mclk); se(32'h2000_903e); end
        join
        dbg.op(4'h2, 1'b1, 32'h0, 1);
        #1 chk("outbound word", 32'ha5a5_0f0f, ext_dtr_rdata);
        se(32'h0000_903e);
        fork
            dbg.op(4'h1, 1'b1, 32'h1234_5678, 1);
            begin @(posedge mclk); sc(32'h4000_903e); end
        join
        dbg.op(4'h1, 1'b1, 32'hdead_beef, 1);
        cop(4'h2, 1'b1, 32'h0);
        #1 chk("inbound word", 32'h1234_5678, core_dtr_rdata);
        sc(32'h0000_903e);
    endtask
    task t_halt;
        @(posedge mclk);
        entry_cause <= 4'h6;
        debug_state <= 1'b1;
        ev(4'h8);
        se(32'h0000_901b);
        outs(6'b101010);
        ev(4'h4);
        se(32'h0000_9019);
        @(posedge mclk);
        debug_state <= 1'b0;
        repeat (2) @(posedge mclk);
        se(32'h0000_901a);
    endtask
    // Debug enable pin low masks mode bits 15:14, high restores them
    task t_dbgen;
        dbg.op(4'h4, 1'b1, 32'h0000_4000, 1);
        se(32'h0000_d01a);
        @(posedge mclk);
        dbgen <= 1'b0;
        repeat (6) @(posedge mclk);
        se(32'h0000_101a);
        outs(6'b001000);
        @(posedge mclk);
        dbgen <= 1'b1;
        repeat (6) @(posedge mclk);
        sc(32'h0000_d01a);
        outs(6'b001011);
    endtask
    task complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        {core_sel, core_rd, core_wr, core_dtr_rd, core_dtr_wr, debug_state} = 6'h0;
        {exit_request, entry_valid, precise_abort, imprecise_abort} = 4'h0;
        core_wdata = 32'h0;
        core_dtr_wdata = 32'h0;
        entry_cause = 4'h0;
        dbgen = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
        t_reset;
        t_ctrl;
        t_abort;
        t_dtr;
        t_halt;
        t_dbgen;
        complete_run;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (2000) @(posedge mclk);
        failures = failures + 1;
        complete_run;
    end
endmodule
